// ===== brd_decoder_top.sv
// per-master boot and remap address decoder for the bus matrix
`timescale 1ns/1ps
module brd_decoder_top #(
    parameter int NUM_MASTERS = 5,
    parameter logic [NUM_MASTERS-1:0] REMAP_MASTERS = 5'h03
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_boot_select_pin,
    input wire logic [NUM_MASTERS-1:0] i_valid,
    input wire logic [NUM_MASTERS-1:0] i_fetch,
    input wire logic [NUM_MASTERS-1:0][31:0] i_addr,
    input wire logic [NUM_MASTERS-1:0] i_remap_cmd,
    output logic o_boot_ready,
    output logic o_boot_internal,
    output logic o_smc_byte_select,
    output logic [4:0] o_smc_bus_width,
    output logic o_smc_strobe_from_cs,
    output logic [NUM_MASTERS-1:0] o_remap,
    output logic [NUM_MASTERS-1:0] o_resp_valid,
    output brd_pkg::brd_slave_t [NUM_MASTERS-1:0] o_slave,
    output logic [NUM_MASTERS-1:0][2:0] o_ext_cs,
    output logic [NUM_MASTERS-1:0] o_abort,
    output logic [NUM_MASTERS-1:0] o_hostif_lcd,
    output logic [NUM_MASTERS-1:0] o_sys_periph,
    output logic [NUM_MASTERS-1:0] o_slot_512,
    output logic [NUM_MASTERS-1:0][brd_pkg::BRD_TRACE_W-1:0] o_trace
);
    import brd_pkg::*;

    //------------------------------------------------------------
    // boot select capture
    //------------------------------------------------------------
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic [1:0] wait_reg;
    logic [1:0] wait_next;
    logic ready_reg;
    logic ready_next;
    logic boot_int_reg;
    logic boot_int_next;
    logic smc_bs_reg;
    logic [4:0] smc_bw_reg;
    logic smc_sc_reg;

    // captured once the sync chain has filled after release; never again
    always_comb begin
        wait_next = wait_reg;
        ready_next = ready_reg;
        boot_int_next = boot_int_reg;
        if (!ready_reg) begin
            if (wait_reg == BRD_SYNC_WAIT) begin
                ready_next = 1'b1;
                boot_int_next = pin_sync_reg;
            end else begin
                wait_next = 2'(wait_reg + 2'h1);
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            wait_reg <= 2'h0;
            ready_reg <= 1'b0;
            boot_int_reg <= 1'b0;
        end else begin
            pin_meta_reg <= i_boot_select_pin;
            pin_sync_reg <= pin_meta_reg;
            wait_reg <= wait_next;
            ready_reg <= ready_next;
            boot_int_reg <= boot_int_next;
        end
    end

    //------------------------------------------------------------
    // per-master remap state and decode
    //------------------------------------------------------------
    logic [NUM_MASTERS-1:0] remap_reg;
    logic [NUM_MASTERS-1:0] remap_next;
    logic [NUM_MASTERS-1:0] valid_next;
    brd_slave_t [NUM_MASTERS-1:0] slave_next;
    logic [NUM_MASTERS-1:0][2:0] cs_next;
    logic [NUM_MASTERS-1:0] abort_next;
    logic [NUM_MASTERS-1:0] lcd_next;
    logic [NUM_MASTERS-1:0] sysp_next;
    logic [NUM_MASTERS-1:0] s512_next;
    logic [NUM_MASTERS-1:0][BRD_TRACE_W-1:0] trace_next;
    logic [NUM_MASTERS-1:0] valid_reg;
    brd_slave_t [NUM_MASTERS-1:0] slave_reg;
    logic [NUM_MASTERS-1:0][2:0] cs_reg;
    logic [NUM_MASTERS-1:0] abort_reg;
    logic [NUM_MASTERS-1:0] lcd_reg;
    logic [NUM_MASTERS-1:0] sysp_reg;
    logic [NUM_MASTERS-1:0] s512_reg;
    logic [NUM_MASTERS-1:0][BRD_TRACE_W-1:0] trace_reg;

    // remap is a one-way command; only reset takes it back
    always_comb begin
        remap_next = remap_reg | i_remap_cmd;
        valid_next = i_valid & {NUM_MASTERS{ready_reg}};
    end

    genvar m;
    generate
        for (m = 0; m < NUM_MASTERS; m++) begin : g_master
            brd_region_decode u_dec (
                .i_addr(i_addr[m]),
                .i_fetch(i_fetch[m]),
                .i_boot_internal(boot_int_reg),
                .i_remap_alias(remap_reg[m] & REMAP_MASTERS[m]),
                .o_slave(slave_next[m]),
                .o_ext_cs(cs_next[m]),
                .o_abort(abort_next[m]),
                .o_hostif_lcd(lcd_next[m]),
                .o_sys_periph(sysp_next[m]),
                .o_slot_512(s512_next[m]),
                .o_trace(trace_next[m])
            );
        end
    endgenerate

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            remap_reg <= '0;
            valid_reg <= '0;
            slave_reg <= '{default: BRD_SL_NONE};
            cs_reg <= '0;
            abort_reg <= '0;
            lcd_reg <= '0;
            sysp_reg <= '0;
            s512_reg <= '0;
            trace_reg <= '0;
        end else begin
            remap_reg <= remap_next;
            valid_reg <= valid_next;
            slave_reg <= slave_next;
            cs_reg <= cs_next;
            abort_reg <= abort_next & valid_next;
            lcd_reg <= lcd_next;
            sysp_reg <= sysp_next;
            s512_reg <= s512_next;
            trace_reg <= trace_next;
        end
    end

    //------------------------------------------------------------
    // outputs
    //------------------------------------------------------------
    // static defaults for an external boot at slow clock; retuning is software's job
    // kept in flops so that every output leaves a register, even a fixed one
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            smc_bs_reg <= BRD_SMC_BYTE_SELECT;
            smc_bw_reg <= BRD_SMC_BUS_WIDTH;
            smc_sc_reg <= BRD_SMC_STROBE_FROM_CS;
        end else begin
            smc_bs_reg <= BRD_SMC_BYTE_SELECT;
            smc_bw_reg <= BRD_SMC_BUS_WIDTH;
            smc_sc_reg <= BRD_SMC_STROBE_FROM_CS;
        end
    end

    assign o_smc_byte_select = smc_bs_reg;
    assign o_smc_bus_width = smc_bw_reg;
    assign o_smc_strobe_from_cs = smc_sc_reg;
    assign o_boot_ready = ready_reg;
    assign o_boot_internal = boot_int_reg;
    assign o_remap = remap_reg;
    assign o_resp_valid = valid_reg;
    assign o_slave = slave_reg;
    assign o_ext_cs = cs_reg;
    assign o_abort = abort_reg;
    assign o_hostif_lcd = lcd_reg;
    assign o_sys_periph = sysp_reg;
    assign o_slot_512 = s512_reg;
    assign o_trace = trace_reg;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    chk_alias_rom: assert property (
        (i_valid[0] && ready_reg && i_addr[0][31:20] == 12'h000 && !remap_reg[0] && boot_int_reg)
        |=> o_slave[0] == BRD_SL_ROM)
        else $error("alias area not on rom");
    chk_alias_ext: assert property (
        (i_valid[0] && ready_reg && i_addr[0][31:20] == 12'h000 && !remap_reg[0] && !boot_int_reg)
        |=> (o_slave[0] == BRD_SL_EBI && o_ext_cs[0] == 3'h0))
        else $error("alias area not on chip select 0");
    chk_alias_remap: assert property (
        (i_valid[1] && i_addr[1][31:20] == 12'h000 && remap_reg[1]) |=> o_slave[1] == BRD_SL_SRAM)
        else $error("remapped alias not on sram");
    chk_boot_hold: assert property (
        ready_reg |=> $stable(boot_int_reg))
        else $error("captured boot select changed");
    chk_boot_capture: assert property (
        $rose(ready_reg) |-> boot_int_reg == $past(pin_sync_reg))
        else $error("boot select captured wrong level");
    chk_remap_sticky: assert property (
        i_remap_cmd[2] |=> o_remap[2] [*3])
        else $error("remap state lost");
    chk_rom_fixed: assert property (
        (i_valid[3] && i_addr[3][31:20] == 12'h004) |=> o_slave[3] == BRD_SL_ROM)
        else $error("rom not at its base");
    chk_ext_slave: assert property (
        (i_valid[4] && i_addr[4][31:28] == 4'h2) |=> (o_slave[4] == BRD_SL_EBI && o_ext_cs[4] == 3'h1))
        else $error("external area misrouted");
    chk_unused_abort: assert property (
        (i_valid[2] && ready_reg && i_addr[2][31:28] == 4'h9) |=> o_abort[2])
        else $error("unused area not aborted");
    chk_lcd_window: assert property (
        (i_valid[0] && i_addr[0][31:20] == 12'h006) |=> (o_slave[0] == BRD_SL_HOSTIF && o_hostif_lcd[0]))
        else $error("display window misrouted");
    chk_reset_remap: assert property (
        $fell(i_reset) |-> o_remap == '0)
        else $error("remap not cleared by reset");
    chk_usb_window: assert property (
        (i_valid[3] && i_addr[3][31:20] == 12'h005) |=> (o_slave[3] == BRD_SL_HOSTIF && !o_hostif_lcd[3]))
        else $error("host controller window misrouted");
    chk_sys_slot: assert property (
        (i_valid[4] && i_addr[4] >= 32'hffff_fc00) |=> (o_sys_periph[4] && o_slot_512[4]))
        else $error("system peripheral slot size wrong");

    cov_boot_rom: cover property ($rose(ready_reg) && boot_int_next);
    cov_boot_ext: cover property ($rose(ready_reg) && !boot_int_next);
    cov_remap_fetch: cover property (o_remap[0] && o_resp_valid[0] && o_slave[0] == BRD_SL_SRAM);
    cov_abort: cover property (o_abort[1]);
endmodule

// ===== brd_decode.sv
// package of map constants plus the per-master region decoder
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
// Overview of operation
// - after any reset, fetches to address zero reach the aliased boot memory
// - addresses zero to 0x000fffff form the boot alias area
// - captured boot select high maps the alias area to the embedded ROM
// - captured boot select low maps the alias area to external chip select 0
// - boot select level is captured once, after reset release when the sync chain has filled, and held until next reset
// - boot select applies unless a REMAP_MASTERS master has remapped; its remap shows internal SRAM instead
// - memories outside the alias stay decodable at fixed bases always
// - host controller window at 0x00500000 goes to the host interface slave
// - display controller window at 0x00600000 goes to the host interface slave
// - external boot runs on slow clock with 16-bit byte-select chip select 0
// - external memory accesses decode to bus matrix slave three
// - trace regions flag SRAM, ROM, external memory and split peripherals
// - system peripherals decode from 0xffffea00 in 256 or 512 byte slots
// - after remap SRAM C appears at zero for processor masters, also at base
// - internal ROM always decodable at 0x00400000
// - unused address areas answer with an abort
package brd_pkg;
    typedef enum logic [2:0] {
        BRD_SL_SRAM = 3'h0,
        BRD_SL_ROM = 3'h1,
        BRD_SL_HOSTIF = 3'h2,
        BRD_SL_EBI = 3'h3,
        BRD_SL_PERIPH = 3'h4,
        BRD_SL_NONE = 3'h7
    } brd_slave_t;
    localparam logic [3:0] BRD_AREA_INTERNAL = 4'h0;
    localparam logic [3:0] BRD_AREA_EXT_FIRST = 4'h1;
    localparam logic [3:0] BRD_AREA_EXT_LAST = 4'h8;
    localparam logic [3:0] BRD_AREA_PERIPH = 4'hf;
    // 1 MB sub-areas of area 0
    localparam logic [7:0] BRD_SUB_ALIAS = 8'h00;
    localparam logic [7:0] BRD_SUB_SRAM_A = 8'h01;
    localparam logic [7:0] BRD_SUB_SRAM_C = 8'h03;
    localparam logic [7:0] BRD_SUB_ROM = 8'h04;
    localparam logic [7:0] BRD_SUB_USB = 8'h05;
    localparam logic [7:0] BRD_SUB_LCD = 8'h06;
    localparam logic [31:0] BRD_TRACE_SRAM_END = 32'h002f_ffff;
    localparam logic [31:0] BRD_TRACE_ROM_BASE = 32'h0040_0000;
    localparam logic [31:0] BRD_TRACE_ROM_END = 32'h004f_ffff;
    localparam logic [31:0] BRD_TRACE_EXT_BASE = 32'h1000_0000;
    localparam logic [31:0] BRD_TRACE_EXT_END = 32'h8fff_ffff;
    localparam logic [31:0] BRD_TRACE_UPER_BASE = 32'hf000_0000;
    localparam logic [31:0] BRD_SYS_TRACE_BASE = 32'hffff_c000;
    localparam logic [31:0] BRD_SYS_PERIPH_BASE = 32'hffff_ea00;
    localparam logic [2:0] BRD_CS0 = 3'h0;
    // external boot defaults driven to the static memory controller
    localparam logic BRD_SMC_BYTE_SELECT = 1'b1;
    localparam logic [4:0] BRD_SMC_BUS_WIDTH = 5'h10;
    localparam logic BRD_SMC_STROBE_FROM_CS = 1'b1;
    localparam logic [1:0] BRD_SYNC_WAIT = 2'h2;
    localparam int BRD_TRACE_W = 8;
endpackage

`timescale 1ns/1ps
module brd_region_decode (
    input wire logic [31:0] i_addr,
    input wire logic i_fetch,
    input wire logic i_boot_internal,
    input wire logic i_remap_alias,
    output brd_pkg::brd_slave_t o_slave,
    output logic [2:0] o_ext_cs,
    output logic o_abort,
    output logic o_hostif_lcd,
    output logic o_sys_periph,
    output logic o_slot_512,
    output logic [brd_pkg::BRD_TRACE_W-1:0] o_trace
);
    import brd_pkg::*;
    logic [3:0] area;
    logic [7:0] sub;
    assign area = i_addr[31:28];
    assign sub = i_addr[27:20];

    always_comb begin
        o_slave = BRD_SL_NONE;
        o_ext_cs = BRD_CS0;
        o_hostif_lcd = 1'b0;
        o_sys_periph = 1'b0;
        o_slot_512 = 1'b0;
        if (area == BRD_AREA_INTERNAL) begin
            if (sub == BRD_SUB_ALIAS) begin
                if (i_remap_alias) begin
                    o_slave = BRD_SL_SRAM;
                end else if (i_boot_internal) begin
                    o_slave = BRD_SL_ROM;
                end else begin
                    o_slave = BRD_SL_EBI;
                end
            end else if (sub >= BRD_SUB_SRAM_A && sub <= BRD_SUB_SRAM_C) begin
                o_slave = BRD_SL_SRAM;
            end else if (sub == BRD_SUB_ROM) begin
                o_slave = BRD_SL_ROM;
            end else if (sub == BRD_SUB_USB) begin
                o_slave = BRD_SL_HOSTIF;
            end else if (sub == BRD_SUB_LCD) begin
                o_slave = BRD_SL_HOSTIF;
                o_hostif_lcd = 1'b1;
            end
        end else if (area >= BRD_AREA_EXT_FIRST && area <= BRD_AREA_EXT_LAST) begin
            o_slave = BRD_SL_EBI;
            o_ext_cs = 3'(area - BRD_AREA_EXT_FIRST);
        end else if (area == BRD_AREA_PERIPH) begin
            o_slave = BRD_SL_PERIPH;
            if (i_addr >= BRD_SYS_PERIPH_BASE) begin
                o_sys_periph = 1'b1;
                // slots from 0xffffea00 are 256 bytes up to 0xfffffc00
                o_slot_512 = (i_addr[15:8] >= 8'hfc);
            end
        end
        o_abort = (o_slave == BRD_SL_NONE);
    end

    // trace comparator inputs: sram d/f, rom d/f, ext d/f, user periph d, sys periph d
    always_comb begin
        o_trace = '0;
        o_trace[0] = !i_fetch && i_addr <= BRD_TRACE_SRAM_END;
        o_trace[1] = i_fetch && i_addr <= BRD_TRACE_SRAM_END;
        o_trace[2] = !i_fetch && i_addr >= BRD_TRACE_ROM_BASE && i_addr <= BRD_TRACE_ROM_END;
        o_trace[3] = i_fetch && i_addr >= BRD_TRACE_ROM_BASE && i_addr <= BRD_TRACE_ROM_END;
        o_trace[4] = !i_fetch && i_addr >= BRD_TRACE_EXT_BASE && i_addr <= BRD_TRACE_EXT_END;
        o_trace[5] = i_fetch && i_addr >= BRD_TRACE_EXT_BASE && i_addr <= BRD_TRACE_EXT_END;
        o_trace[6] = !i_fetch && i_addr >= BRD_TRACE_UPER_BASE && i_addr < BRD_SYS_TRACE_BASE;
        o_trace[7] = !i_fetch && i_addr >= BRD_SYS_TRACE_BASE;
    end
endmodule

// ===== brd_master_model.sv
// bus master model driving requests and remap commands into the decoder
`timescale 1ns/1ps
module brd_master_model #(
    parameter int N = 5
) (
    input wire logic i_clk,
    output logic [N-1:0] o_valid,
    output logic [N-1:0] o_fetch,
    output logic [N-1:0][31:0] o_addr,
    output logic [N-1:0] o_remap_cmd
);
    initial begin
        o_valid = '0;
        o_fetch = '0;
        o_addr = '0;
        o_remap_cmd = '0;
    end

    // one request; released lines show the inverse so stale values never match
    task automatic req(input int m, input logic [31:0] a, input logic f);
        @(posedge i_clk);
        o_valid[m] <= 1'b1;
        o_addr[m] <= a;
        o_fetch[m] <= f;
        @(posedge i_clk);
        o_valid[m] <= 1'b0;
        o_addr[m] <= ~a;
        o_fetch[m] <= ~f;
        #1;
    endtask

    // remap is issued for one master at a time
    task automatic remap(input int m);
        @(posedge i_clk);
        o_remap_cmd[m] <= 1'b1;
        @(posedge i_clk);
        o_remap_cmd[m] <= 1'b0;
        #1;
    endtask
endmodule

// ===== brd_decoder_top_test.sv
// self-checking bench for the boot and remap address decoder
`timescale 1ns/1ps
module brd_decoder_top_test;
    import brd_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic pin = 1'b1;
    logic boot_ready, boot_int, smc_bs, smc_sc;
    logic [4:0] smc_bw;
    logic [4:0] valid, fetch, remap_cmd, remap, resp_valid, abort, lcd, sysp, slot;
    logic [4:0][31:0] addr;
    brd_slave_t [4:0] slave;
    logic [4:0][2:0] ext_cs;
    logic [4:0][7:0] trace;
    int error_cnt = 0;
    int compares = 0;
    logic [31:0] map_addr [11] = '{32'h0010_0000, 32'h0030_0000, 32'h0040_0000, 32'h0050_0000,
        32'h0060_0000, 32'h0070_0000, 32'h1000_0000, 32'h8fff_fffc, 32'h9000_0000,
        32'hffff_ea00, 32'hefff_fffc};
    // {abort, slave}
    logic [3:0] map_exp [11] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h2, 4'hf, 4'h3, 4'h3, 4'hf, 4'h4, 4'hf};
    logic [32:0] tr_req [9] = '{{1'b1, 32'h002f_fffc}, {1'b0, 32'h0}, {1'b1, 32'h0040_0000},
        {1'b0, 32'h004f_fffc}, {1'b1, 32'h8fff_fffc}, {1'b0, 32'h1000_0000}, {1'b0, 32'hf000_0000},
        {1'b0, 32'hffff_c000}, {1'b0, 32'h0030_0000}};
    logic [7:0] tr_exp [9] = '{8'h02, 8'h01, 8'h08, 8'h04, 8'h20, 8'h10, 8'h40, 8'h80, 8'h00};

    always #50 i_clk = ~i_clk;

    brd_master_model #(.N(5)) mdl_u (.i_clk(i_clk), .o_valid(valid), .o_fetch(fetch), .o_addr(addr),
        .o_remap_cmd(remap_cmd));

    brd_decoder_top #(.NUM_MASTERS(5)) dut_u (.i_clk(i_clk), .i_reset(i_reset),
        .i_boot_select_pin(pin), .i_valid(valid), .i_fetch(fetch), .i_addr(addr), .i_remap_cmd(remap_cmd),
        .o_boot_ready(boot_ready), .o_boot_internal(boot_int), .o_smc_byte_select(smc_bs),
        .o_smc_bus_width(smc_bw), .o_smc_strobe_from_cs(smc_sc), .o_remap(remap),
        .o_resp_valid(resp_valid), .o_slave(slave), .o_ext_cs(ext_cs), .o_abort(abort),
        .o_hostif_lcd(lcd), .o_sys_periph(sysp), .o_slot_512(slot), .o_trace(trace));

    //------------------------------------------------------------
    // shared checks
    //------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // reset with a pin level, probe refusal before ready, then boot fetch
    task automatic t_boot(input logic lvl);
        int n;
        brd_slave_t boot_sl;
        boot_sl = lvl ? BRD_SL_ROM : BRD_SL_EBI;
        @(posedge i_clk);
        i_reset <= 1'b1;
        pin <= lvl;
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        mdl_u.req(2, 32'h9000_0000, 1'b0);
        check(32'({resp_valid[2], abort[2]}), 32'h0);
        n = 0;
        while (boot_ready !== 1'b1 && n < 20) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (boot_ready !== 1'b1) begin
            error_cnt++;
            finish_test();
        end
        check(32'(boot_int), 32'(lvl));
        check(32'({smc_bs, smc_bw, smc_sc}), 32'h61);
        check(32'(remap), 32'h0);
        mdl_u.req(0, 32'h0, 1'b1);
        check(32'({resp_valid[0], slave[0]}), 32'(boot_sl) | 32'h8);
        check(32'(ext_cs[0]), 32'h0);
        mdl_u.req(1, 32'h000f_fffc, 1'b0);
        check(32'(slave[1]), 32'(boot_sl));
        $display("boot test done, pin %0d", lvl);
    endtask

    task automatic t_map();
        for (int i = 0; i < 11; i++) begin
            mdl_u.req(2, map_addr[i], 1'b0);
            check(32'({abort[2], slave[2]}), 32'(map_exp[i]));
        end
        mdl_u.req(3, 32'h8fff_fffc, 1'b0);
        check(32'(ext_cs[3]), 32'h7);
        mdl_u.req(3, 32'h0050_0000, 1'b0);
        check(32'(lcd[3]), 32'h0);
        mdl_u.req(3, 32'h0060_0000, 1'b0);
        check(32'(lcd[3]), 32'h1);
        mdl_u.req(0, 32'h0060_0000, 1'b0);
        check(32'({slave[0], lcd[0]}), 32'h5);
        mdl_u.req(3, 32'h0040_0000, 1'b0);
        check(32'(slave[3]), 32'(BRD_SL_ROM));
        mdl_u.req(4, 32'h2000_0000, 1'b0);
        check(32'({slave[4], ext_cs[4]}), 32'h19);
        mdl_u.req(4, 32'hffff_ea00, 1'b0);
        check(32'({sysp[4], slot[4]}), 32'h2);
        mdl_u.req(4, 32'hffff_fc00, 1'b0);
        check(32'({sysp[4], slot[4]}), 32'h3);
        mdl_u.req(4, 32'hffff_e9fc, 1'b0);
        check(32'(sysp[4]), 32'h0);
        $display("map test done");
    endtask

    task automatic t_trace();
        for (int i = 0; i < 9; i++) begin
            mdl_u.req(1, tr_req[i][31:0], tr_req[i][32]);
            check(32'(trace[1]), 32'(tr_exp[i]));
        end
        $display("trace test done");
    endtask

    // booted from rom; pin moves afterwards and must be ignored
    task automatic t_remap();
        @(posedge i_clk);
        pin <= 1'b0;
        repeat (5) @(posedge i_clk);
        #1;
        check(32'(boot_int), 32'h1);
        mdl_u.remap(0);
        check(32'(remap), 32'h01);
        mdl_u.req(0, 32'h0, 1'b1);
        check(32'(slave[0]), 32'(BRD_SL_SRAM));
        mdl_u.req(1, 32'h0, 1'b0);
        check(32'(slave[1]), 32'(BRD_SL_ROM));
        mdl_u.remap(1);
        mdl_u.remap(2);
        check(32'(remap), 32'h07);
        mdl_u.req(1, 32'h0, 1'b0);
        check(32'(slave[1]), 32'(BRD_SL_SRAM));
        mdl_u.req(2, 32'h0, 1'b0);
        check(32'(slave[2]), 32'(BRD_SL_ROM));
        mdl_u.req(0, 32'h0030_0000, 1'b0);
        check(32'(slave[0]), 32'(BRD_SL_SRAM));
        mdl_u.req(0, 32'h0040_0000, 1'b0);
        check(32'(slave[0]), 32'(BRD_SL_ROM));
        $display("remap test done");
    endtask

    initial begin
        t_boot(1'b1);
        t_map();
        t_trace();
        t_remap();
        t_boot(1'b0);
        finish_test();
    end
endmodule
